// ### bench/sler_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Watches command answers and the two read ports of the core
module sler_chk (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_features,
  input wire logic [7:0]  cmd_lba_mid,
  input wire logic [7:0]  cmd_lba_high,
  input wire logic        attr_rd_fail,
  input wire logic        attr_wr_fail,
  input wire logic        attr_fail_idnf,
  input wire logic        resp_valid,
  input wire logic [7:0]  resp_status,
  input wire logic [7:0]  resp_error,
  input wire logic        smart_enabled,
  input wire logic        log_rd,
  input wire logic [7:0]  log_addr,
  input wire logic [8:0]  log_idx,
  input wire logic        log_rvalid,
  input wire logic [7:0]  log_rdata
);
  // Key and known subcommand decode
  wire logic key_ok = cmd_lba_mid == 8'h4F && cmd_lba_high == 8'hC2;
  wire logic sub_ok = cmd_features inside {[8'hD0:8'hD6], [8'hD8:8'hDA]};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Command carrying the key
  sequence s_keyed;
    cmd_valid && key_ok;
  endsequence
  // Abort answer
  sequence s_abort;
    resp_valid && resp_status == 8'h51 && resp_error == 8'h04;
  endsequence
  resp_pulse_a: assert property (cmd_valid |=> resp_valid) else $error("answer missing");
  resp_hold_a: assert property (!cmd_valid |=> !resp_valid && $stable(resp_status)
    && $stable(resp_error)) else $error("answer moved");
  key_miss_a: assert property (cmd_valid && !key_ok |=> s_abort) else $error("key");
  bad_sub_a: assert property (s_keyed ##0 !sub_ok |=> s_abort) else $error("sub");
  disabled_a: assert property (cmd_valid && !smart_enabled && cmd_features != 8'hD8
    |=> s_abort) else $error("disabled accepted");
  enable_cmd_a: assert property (s_keyed ##0 cmd_features == 8'hD8
    |=> smart_enabled && resp_status == 8'h50) else $error("enable failed");
  attr_rd_a: assert property (s_keyed ##0 (smart_enabled && attr_rd_fail
    && cmd_features inside {8'hD0, 8'hD1}) |=> resp_status == 8'h51
    && resp_error == ($past(attr_fail_idnf) ? 8'h10 : 8'h40)) else $error("read fail");
  attr_wr_a: assert property (s_keyed ##0 (smart_enabled && attr_wr_fail
    && cmd_features == 8'hD3) |=> resp_status == 8'h51
    && resp_error == ($past(attr_fail_idnf) ? 8'h10 : 8'h01)) else $error("write fail");
  log_pulse_a: assert property (log_rd |=> log_rvalid) else $error("log unanswered");
  log_quiet_a: assert property (!log_rvalid |-> log_rdata == 8'h00) else $error("log data");
  reg_quiet_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("reg");
  err_ptr_a: assert property (log_rd && log_addr == 8'h01 && log_idx == 9'h001
    |=> log_rdata inside {[8'h01:8'h05]}) else $error("error pointer");
  st_ptr_a: assert property (log_rd && log_addr == 8'h06 && log_idx == 9'h1FC
    |=> log_rdata <= 8'h15) else $error("self-test pointer");
  version_a: assert property (log_rd && log_addr inside {8'h00, 8'h01}
    && log_idx == 9'h000 |=> log_rdata == 8'h01) else $error("version byte");
  dir_host_a: assert property (log_rd && log_addr == 8'h00 && !log_idx[0]
    && log_idx inside {[9'h100:9'h13E]} |=> log_rdata == 8'h10) else $error("dir size");
endmodule
bind sler_core sler_chk u_chk (
  .clk_sys, .reset, .reg_rd, .reg_rdata, .cmd_valid, .cmd_features, .cmd_lba_mid,
  .cmd_lba_high, .attr_rd_fail, .attr_wr_fail, .attr_fail_idnf, .resp_valid,
  .resp_status, .resp_error, .smart_enabled, .log_rd, .log_addr, .log_idx,
  .log_rvalid, .log_rdata
);
`default_nettype wire

// ### bench/sler_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side: issues commands and moves log bytes
module sler_host_model (
  input  wire logic       clk_sys,
  output logic            cmd_valid,
  output logic [7:0]      cmd_features,
  output logic [7:0]      cmd_lba_mid,
  output logic [7:0]      cmd_lba_high,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_status,
  input  wire logic [7:0] resp_error,
  output logic            log_rd,
  output logic            log_wr,
  output logic [7:0]      log_addr,
  output logic [8:0]      log_idx,
  output logic [7:0]      log_wdata,
  input  wire logic       log_rvalid,
  input  wire logic [7:0] log_rdata
);
  // Idle at time zero
  initial begin
    {cmd_valid, log_rd, log_wr, cmd_features, cmd_lba_mid, cmd_lba_high} = '0;
    {log_addr, log_wdata, log_idx} = '0;
  end
  // One command, answer taken in its pulse
  task automatic cmd(input logic [7:0] f, m, h, output logic [7:0] s, e);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_features <= f;
    cmd_lba_mid <= m;
    cmd_lba_high <= h;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_features <= ~f;
    #1;
    s = (resp_valid === 1'b1) ? resp_status : 8'hxx;
    e = resp_error;
  endtask
  // One log byte read
  task automatic rd(input logic [7:0] a, input logic [8:0] i, output logic [7:0] d);
    @(posedge clk_sys);
    log_rd <= 1'b1;
    log_addr <= a;
    log_idx <= i;
    @(posedge clk_sys);
    log_rd <= 1'b0;
    log_idx <= ~i;
    #1;
    d = (log_rvalid === 1'b1) ? log_rdata : 8'hxx;
  endtask
  // One log byte write; data inverted after
  task automatic wr(input logic [7:0] a, input logic [8:0] i, input logic [7:0] d);
    @(posedge clk_sys);
    log_wr <= 1'b1;
    log_addr <= a;
    log_idx <= i;
    log_wdata <= d;
    @(posedge clk_sys);
    log_wr <= 1'b0;
    log_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the log and error-report core
module testbench;
  logic                       clk_sys;
  logic                       reset = 1'b1;
  logic [7:0]                 reg_addr = '0;
  logic [31:0]                reg_wdata = '0, st_lba = '0;
  logic                       reg_wr = 1'b0, reg_rd = 1'b0, ev_err = 1'b0, ev_st = 1'b0;
  logic                       attr_rd_fail = 1'b0, attr_wr_fail = 1'b0, attr_fail_idnf = 1'b0;
  logic [4:0][63:0]           err_cmd_regs = '0;
  logic [4:0][31:0]           err_cmd_ms = '0;
  logic [55:0]                err_regs = '0;
  logic [151:0]               err_vendor = '0;
  sler_pkg::sler_dev_state_type err_state = sler_pkg::SLER_ST_UNKNOWN;
  logic [3:0]                 err_state_vs = '0;
  logic [15:0]                err_hours = '0, st_hours = '0;
  logic [7:0]                 st_number = '0, st_status = '0, st_checkpoint = '0;
  logic [63:0]                sel_cur_lba = 64'h0123_4567_89AB_CDEF;
  logic [15:0]                sel_cur_span = 16'h0203;
  wire logic [31:0]           reg_rdata;
  wire logic                  cmd_valid, resp_valid, smart_enabled, log_rd, log_wr, log_rvalid;
  wire logic [7:0]            cmd_features, cmd_lba_mid, cmd_lba_high, resp_status;
  wire logic [7:0]            resp_error, log_addr, log_wdata, log_rdata;
  wire logic [8:0]            log_idx;
  int                         n_fail, total_checks, i, e, s, b;
  logic [7:0]                 f, n, d, sum;
  // Core under test and its host
  sler_core u_dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cmd_valid, .cmd_features, .cmd_lba_mid, .cmd_lba_high, .attr_rd_fail, .attr_wr_fail,
    .attr_fail_idnf, .resp_valid, .resp_status, .resp_error, .smart_enabled, .ev_err,
    .err_cmd_regs, .err_cmd_ms, .err_regs, .err_vendor, .err_state, .err_state_vs,
    .err_hours, .ev_st, .st_number, .st_status, .st_hours, .st_checkpoint, .st_lba,
    .sel_cur_lba, .sel_cur_span, .log_rd, .log_wr, .log_addr, .log_idx, .log_wdata,
    .log_rvalid, .log_rdata);
  sler_host_model u_host (.clk_sys, .cmd_valid, .cmd_features, .cmd_lba_mid, .cmd_lba_high,
    .resp_valid, .resp_status, .resp_error, .log_rd, .log_wr, .log_addr, .log_idx,
    .log_wdata, .log_rvalid, .log_rdata);
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Register write and checked read
  task automatic wreg(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic creg(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, x);
  endtask
  // Checked log byte and checked command
  task automatic lchk(input logic [7:0] a, input int i, input logic [7:0] x);
    logic [7:0] g;
    u_host.rd(a, 9'(i), g);
    chk(32'(g), 32'(x));
  endtask
  task automatic ccmd(input logic [7:0] f, m, h, input logic [15:0] x);
    logic [7:0] s, e;
    u_host.cmd(f, m, h, s, e);
    chk(32'({s, e}), 32'(x));
  endtask
  // Failure levels seen by the next command
  task automatic att(input logic r, w, i);
    @(posedge clk_sys);
    attr_rd_fail <= r;
    attr_wr_fail <= w;
    attr_fail_idnf <= i;
  endtask
  // Run cut short if it hangs
  initial begin
    #700_000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    creg(8'h04, 32'h0000_0005);
    creg(8'h0C, 32'h0000_0000);
    wreg(8'h04, 32'hFFFF_FFFF);
    creg(8'h04, 32'h0000_0005);
    lchk(8'h06, 'h1FC, 8'h00);
    lchk(8'h00, 1, 8'h00);
    lchk(8'h00, 2, 8'h01);
    lchk(8'h00, 'h13E, 8'h10);
    lchk(8'h00, 'h140, 8'h00);
    // Every subcommand code from D0 to DB except D9, with the key
    for (f = 8'hD0; f <= 8'hDB; f++) begin
      if (f != 8'hD9) begin
        ccmd(f, 8'h4F, 8'hC2, (f == 8'hD7 || f == 8'hDB) ? 16'h5104 : 16'h5000);
      end
    end
    ccmd(8'hD0, 8'h4F, 8'h00, 16'h5104);
    ccmd(8'hD0, 8'h00, 8'hC2, 16'h5104);
    ccmd(8'hD9, 8'h4F, 8'hC2, 16'h5000);
    ccmd(8'hD0, 8'h4F, 8'hC2, 16'h5104);
    ccmd(8'hD9, 8'h4F, 8'hC2, 16'h5104);
    ccmd(8'hD8, 8'h4F, 8'hC2, 16'h5000);
    att(1'b1, 1'b0, 1'b0);
    ccmd(8'hD0, 8'h4F, 8'hC2, 16'h5140);
    att(1'b1, 1'b0, 1'b1);
    ccmd(8'hD1, 8'h4F, 8'hC2, 16'h5110);
    att(1'b0, 1'b1, 1'b0);
    ccmd(8'hD3, 8'h4F, 8'hC2, 16'h5101);
    att(1'b0, 1'b1, 1'b1);
    ccmd(8'hD3, 8'h4F, 8'hC2, 16'h5110);
    creg(8'h08, 32'h0000_1051);
    att(1'b0, 1'b0, 1'b0);
    wreg(8'h00, 32'h0000_0000);
    creg(8'h00, 32'h0000_0000);
    wreg(8'h00, 32'h0000_0001);
    #1;
    chk(32'(smart_enabled), 32'h0000_0001);
    // Six errors; sixth wraps to slot one
    for (e = 1; e <= 6; e++) begin
      f = 8'h20 + 8'(e);
      @(posedge clk_sys);
      ev_err <= 1'b1;
      err_cmd_regs <= {40{f}};
      err_cmd_ms <= {5{f, 24'h00_1122}};
      err_regs <= {7{f}};
      err_vendor <= {19{f}};
      err_state <= sler_pkg::sler_dev_state_type'(e % 5);
      err_state_vs <= 4'h9;
      err_hours <= {f, 8'h33};
      @(posedge clk_sys);
      ev_err <= 1'b0;
      s = (e - 1) % 5 + 1;
      b = 2 + (s - 1) * 90;
      lchk(8'h01, 1, 8'(s));
      lchk(8'h01, b + 7, f);
      lchk(8'h01, b + 8, 8'h22);
      lchk(8'h01, b + 11, f);
      lchk(8'h01, b + 'h3D, f);
      lchk(8'h01, b + 'h57, {4'h9, 4'(e % 5)});
      lchk(8'h01, b + 'h59, f);
    end
    lchk(8'h01, 'h5C + 7, 8'h22);
    lchk(8'h01, 'h1C4, 8'h06);
    // Count held at its top value
    @(posedge clk_sys);
    ev_err <= 1'b1;
    repeat (65535) @(posedge clk_sys);
    ev_err <= 1'b0;
    creg(8'h04, 32'hFFFF_0001);
    // 22 self-test results; last overwrites oldest
    for (n = 8'h01; n <= 8'h16; n++) begin
      @(posedge clk_sys);
      ev_st <= 1'b1;
      st_number <= n;
      st_status <= 8'h70;
      st_hours <= {n, 8'h44};
      st_checkpoint <= 8'h55;
      st_lba <= {n, 24'h66_7788};
      @(posedge clk_sys);
      ev_st <= 1'b0;
      lchk(8'h06, 'h1FC, (n > 8'h15) ? n - 8'h15 : n);
    end
    lchk(8'h06, 2, 8'h16);
    lchk(8'h06, 'h1A, 8'h02);
    lchk(8'h06, 'h1E2, 8'h15);
    lchk(8'h06, 5, 8'h16);
    lchk(8'h06, 9, 8'h88);
    lchk(8'h06, 'h0C, 8'h16);
    // Span table read back; progress fields read-only
    for (i = 2; i < 'h52; i++) u_host.wr(8'h09, 9'(i), 8'(i) ^ 8'hA5);
    for (i = 2; i < 'h52; i++) lchk(8'h09, i, 8'(i) ^ 8'hA5);
    u_host.wr(8'h09, 9'h1EC, 8'hFF);
    u_host.wr(8'h01, 9'h000, 8'hFF);
    lchk(8'h01, 0, 8'h01);
    lchk(8'h09, 'h1EC, 8'hEF);
    lchk(8'h09, 'h1F3, 8'h01);
    lchk(8'h09, 'h1F4, 8'h03);
    // Every sector sums to zero
    for (f = 8'h00; f <= 8'h09; f++) begin
      sum = 8'h00;
      for (i = 0; i < 512; i++) begin
        u_host.rd(f, 9'(i), d);
        sum += d;
      end
      chk(32'(sum), 32'h0000_0000);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ### rtl/sler_core.sv
`timescale 1ns/1ns
`default_nettype none

module sler_core #(
  parameter logic SMART_EN_RESET = 1'b1
) (
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  // Register port
  input  wire logic [7:0]                        reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [31:0]                       reg_rdata,
  // Health-monitoring command check
  input  wire logic                              cmd_valid,
  input  wire logic [7:0]                        cmd_features,
  input  wire logic [7:0]                        cmd_lba_mid,
  input  wire logic [7:0]                        cmd_lba_high,
  input  wire logic                              attr_rd_fail,
  input  wire logic                              attr_wr_fail,
  input  wire logic                              attr_fail_idnf,
  output logic                                   resp_valid,
  output logic      [7:0]                        resp_status,
  output logic      [7:0]                        resp_error,
  output logic                                   smart_enabled,
  // Error event with its snapshots
  input  wire logic                              ev_err,
  input  wire logic [sler_pkg::CMD_SNAPS-1:0][63:0] err_cmd_regs,
  input  wire logic [sler_pkg::CMD_SNAPS-1:0][31:0] err_cmd_ms,
  input  wire logic [55:0]                       err_regs,
  input  wire logic [151:0]                      err_vendor,
  input  wire sler_pkg::sler_dev_state_type      err_state,
  input  wire logic [3:0]                        err_state_vs,
  input  wire logic [15:0]                       err_hours,
  // Self-test completion event
  input  wire logic                              ev_st,
  input  wire logic [7:0]                        st_number,
  input  wire logic [7:0]                        st_status,
  input  wire logic [15:0]                       st_hours,
  input  wire logic [7:0]                        st_checkpoint,
  input  wire logic [31:0]                       st_lba,
  // Selective test progress
  input  wire logic [63:0]                       sel_cur_lba,
  input  wire logic [15:0]                       sel_cur_span,
  // Log sector byte port
  input  wire logic                              log_rd,
  input  wire logic                              log_wr,
  input  wire logic [7:0]                        log_addr,
  input  wire logic [8:0]                        log_idx,
  input  wire logic [7:0]                        log_wdata,
  output logic                                   log_rvalid,
  output logic      [7:0]                        log_rdata
);

  // Whole module state
  typedef struct packed {
    logic [2:0]        err_ptr;     // Newest error slot
    logic [4:0]        st_ptr;      // Newest self-test slot
    logic [15:0]       err_cnt;     // Saturating error count
    logic              smart_en;    // Monitoring enabled
    logic              resp_valid;  // Answer pulse
    logic [7:0]        resp_status; // Last status answer
    logic [7:0]        resp_error;  // Last error answer
    logic [31:0]       reg_rdata;   // Register read data
    logic              log_rvalid;  // Log read pulse
    logic [7:0]        log_rdata;   // Log read byte
    logic [511:0][7:0] err_mem;     // Error log sector
    logic [511:0][7:0] st_mem;      // Self-test log sector
    logic [511:0][7:0] sel_mem;     // Selective log sector
  } sler_state_type;

  // Reset image
  localparam sler_state_type RESET_STATE = '{
    err_ptr  : sler_pkg::ERR_SLOTS,
    smart_en : SMART_EN_RESET,
    default  : '0
  };

  sler_state_type q; // Registered state
  sler_state_type d; // Next state

  // Valid subcommand codes
  function automatic logic sub_known(input logic [7:0] f);
    sub_known = (f == sler_pkg::SUB_RD_VAL)  || (f == sler_pkg::SUB_RD_THR) ||
                (f == sler_pkg::SUB_AUTOSV)  || (f == sler_pkg::SUB_SAVE)   ||
                (f == sler_pkg::SUB_OFFLN)   || (f == sler_pkg::SUB_RD_LOG) ||
                (f == sler_pkg::SUB_WR_LOG)  || (f == sler_pkg::SUB_ENABLE) ||
                (f == sler_pkg::SUB_DISABLE) || (f == sler_pkg::SUB_STATUS);
  endfunction

  // One byte of a log sector, checksum slot excluded
  function automatic logic [7:0] sec_byte(input sler_state_type s, input logic [7:0] la,
                                          input logic [8:0] i);
    logic [7:0] b;
    b = '0;
    if (la == sler_pkg::LOG_DIR) begin
      // Version word, then one count byte per log address
      if (i == 9'(0)) begin
        b = sler_pkg::LOG_VERSION;
      end else if (!i[0]) begin
        if (i[8:1] >= sler_pkg::LOG_HOST_LO && i[8:1] <= sler_pkg::LOG_HOST_HI) begin
          b = sler_pkg::HOST_SECTORS;
        end else if (i[8:1] == sler_pkg::LOG_ERR || i[8:1] == sler_pkg::LOG_ST ||
                     i[8:1] == sler_pkg::LOG_SEL) begin
          b = sler_pkg::ONE_SECTOR;
        end
      end
    end else if (la == sler_pkg::LOG_ERR) begin
      // Fixed header and count overlay the stored entries
      if (i == 9'(0)) begin
        b = sler_pkg::ERR_VERSION;
      end else if (i == 9'(sler_pkg::ERR_PTR_OFS)) begin
        b = {5'h00, s.err_ptr};
      end else if (i == 9'(sler_pkg::ERR_CNT_OFS)) begin
        b = s.err_cnt[7:0];
      end else if (i == 9'(sler_pkg::ERR_CNT_OFS + 1)) begin
        b = s.err_cnt[15:8];
      end else begin
        b = s.err_mem[i];
      end
    end else if (la == sler_pkg::LOG_ST) begin
      // Revision word and pointer overlay the descriptors
      if (i == 9'(0)) begin
        b = sler_pkg::ST_REV;
      end else if (i == 9'(sler_pkg::ST_PTR_OFS)) begin
        b = {3'h0, s.st_ptr};
      end else begin
        b = s.st_mem[i];
      end
    end else if (la == sler_pkg::LOG_SEL) begin
      // Progress fields come live from the test engine
      if (i >= 9'(sler_pkg::SEL_CUR_LBA) && i < 9'(sler_pkg::SEL_CUR_SPAN)) begin
        b = sel_cur_lba[8*(i-9'(sler_pkg::SEL_CUR_LBA)) +: 8];
      end else if (i >= 9'(sler_pkg::SEL_CUR_SPAN) && i < 9'(sler_pkg::SEL_RO_END)) begin
        b = sel_cur_span[8*(i-9'(sler_pkg::SEL_CUR_SPAN)) +: 8];
      end else begin
        b = s.sel_mem[i];
      end
    end
    sec_byte = b;
  endfunction

  // Next-state logic
  always_comb begin
    logic [7:0] sum;
    logic [2:0] eslot;
    logic [4:0] sslot;
    int         base;
    int         es;
    sum   = '0;
    eslot = '0;
    sslot = '0;
    base  = 0;
    es    = 0;
    d = q;
    d.resp_valid = 1'b0;
    d.log_rvalid = 1'b0;
    d.reg_rdata  = '0;
    d.log_rdata  = '0;

    // Register writes steer the enable
    if (reg_wr && reg_addr == sler_pkg::REG_CTRL) begin
      d.smart_en = reg_wdata[0];
    end

    // Register reads show block state
    if (reg_rd) begin
      if (reg_addr == sler_pkg::REG_CTRL) begin
        d.reg_rdata = {31'h0000_0000, q.smart_en};
      end else if (reg_addr == sler_pkg::REG_STAT) begin
        d.reg_rdata = {q.err_cnt, 3'h0, q.st_ptr, 5'h00, q.err_ptr};
      end else if (reg_addr == sler_pkg::REG_RESP) begin
        d.reg_rdata = {16'h0000, q.resp_error, q.resp_status};
      end
    end

    // Command check, in order of precedence
    if (cmd_valid) begin
      d.resp_valid  = 1'b1;
      d.resp_status = sler_pkg::STS_OK;
      d.resp_error  = sler_pkg::ERR_NONE;
      if (cmd_lba_mid != sler_pkg::KEY_MID || cmd_lba_high != sler_pkg::KEY_HIGH) begin
        // Key absent
        d.resp_status = sler_pkg::STS_FAIL;
        d.resp_error  = sler_pkg::ERR_ABORT;
      end else if (!sub_known(cmd_features)) begin
        // Unknown subcommand
        d.resp_status = sler_pkg::STS_FAIL;
        d.resp_error  = sler_pkg::ERR_ABORT;
      end else if (!q.smart_en && cmd_features != sler_pkg::SUB_ENABLE) begin
        // Monitoring off
        d.resp_status = sler_pkg::STS_FAIL;
        d.resp_error  = sler_pkg::ERR_ABORT;
      end else if (attr_rd_fail && (cmd_features == sler_pkg::SUB_RD_VAL ||
                                    cmd_features == sler_pkg::SUB_RD_THR)) begin
        // Structure unreadable
        d.resp_status = sler_pkg::STS_FAIL;
        d.resp_error  = attr_fail_idnf ? sler_pkg::ERR_IDNF : sler_pkg::ERR_UNC;
      end else if (attr_wr_fail && cmd_features == sler_pkg::SUB_SAVE) begin
        // Structure unwritable
        d.resp_status = sler_pkg::STS_FAIL;
        d.resp_error  = attr_fail_idnf ? sler_pkg::ERR_IDNF : sler_pkg::ERR_AMNF;
      end else if (cmd_features == sler_pkg::SUB_ENABLE) begin
        d.smart_en = 1'b1;
      end else if (cmd_features == sler_pkg::SUB_DISABLE) begin
        d.smart_en = 1'b0;
      end
    end

    // New error entry
    if (ev_err) begin
      eslot = (q.err_ptr == sler_pkg::ERR_SLOTS) ? 3'h1 : q.err_ptr + 3'h1;
      d.err_ptr = eslot;
      if (q.err_cnt != sler_pkg::ERR_CNT_MAX) begin
        d.err_cnt = q.err_cnt + 16'h0001;
      end
      base = sler_pkg::ERR_FIRST + (int'(eslot) - 1) * sler_pkg::ERR_ENTRY;
      for (int k = 0; k < sler_pkg::CMD_SNAPS; k++) begin
        // Command snapshot k
        for (int b = 0; b < sler_pkg::CMD_REGS; b++) begin
          d.err_mem[base + k*sler_pkg::CMD_SNAP + b] = err_cmd_regs[k][8*b +: 8];
        end
        for (int b = 0; b < 4; b++) begin
          d.err_mem[base + k*sler_pkg::CMD_SNAP + sler_pkg::CMD_MS_OFS + b] =
            err_cmd_ms[k][8*b +: 8];
        end
      end
      es = base + sler_pkg::ERR_SNAP_OFS;
      d.err_mem[es] = '0;
      for (int b = 0; b < sler_pkg::ERR_REGS; b++) begin
        d.err_mem[es + sler_pkg::ERR_REGS_OFS + b] = err_regs[8*b +: 8];
      end
      for (int b = 0; b < sler_pkg::ERR_VEND; b++) begin
        d.err_mem[es + sler_pkg::ERR_VEND_OFS + b] = err_vendor[8*b +: 8];
      end
      d.err_mem[es + sler_pkg::STATE_OFS] = {err_state_vs, err_state};
      d.err_mem[es + sler_pkg::HOURS_OFS]     = err_hours[7:0];
      d.err_mem[es + sler_pkg::HOURS_OFS + 1] = err_hours[15:8];
    end

    // New self-test descriptor
    if (ev_st) begin
      sslot = (q.st_ptr == sler_pkg::ST_SLOTS) ? 5'h01 : q.st_ptr + 5'h01;
      d.st_ptr = sslot;
      base = sler_pkg::ST_FIRST + (int'(sslot) - 1) * sler_pkg::ST_DESC;
      for (int b = 0; b < sler_pkg::ST_DESC; b++) begin
        d.st_mem[base + b] = '0;
      end
      d.st_mem[base + sler_pkg::ST_NUM_REL]      = st_number;
      d.st_mem[base + sler_pkg::ST_STAT_REL]     = st_status;
      d.st_mem[base + sler_pkg::ST_HRS_REL]      = st_hours[7:0];
      d.st_mem[base + sler_pkg::ST_HRS_REL + 1]  = st_hours[15:8];
      d.st_mem[base + sler_pkg::ST_CKPT_REL]     = st_checkpoint;
      for (int b = 0; b < 4; b++) begin
        d.st_mem[base + sler_pkg::ST_LBA_REL + b] = st_lba[8*b +: 8];
      end
    end

    // Host writes to the selective log, progress and checksum skipped
    if (log_wr && log_addr == sler_pkg::LOG_SEL &&
        !(log_idx >= 9'(sler_pkg::SEL_CUR_LBA) && log_idx < 9'(sler_pkg::SEL_RO_END)) &&
        log_idx != 9'(sler_pkg::CHK_OFS)) begin
      d.sel_mem[log_idx] = log_wdata;
    end

    // Log read, checksum formed over the first 511 bytes
    if (log_rd) begin
      d.log_rvalid = 1'b1;
      if (log_idx == 9'(sler_pkg::CHK_OFS)) begin
        for (int i = 0; i < sler_pkg::CHK_OFS; i++) begin
          sum = sum + sec_byte(q, log_addr, 9'(i));
        end
        d.log_rdata = 8'h00 - sum;
      end else begin
        d.log_rdata = sec_byte(q, log_addr, log_idx);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign reg_rdata     = q.reg_rdata;
  assign resp_valid    = q.resp_valid;
  assign resp_status   = q.resp_status;
  assign resp_error    = q.resp_error;
  assign smart_enabled = q.smart_en;
  assign log_rvalid    = q.log_rvalid;
  assign log_rdata     = q.log_rdata;

endmodule

`default_nettype wire

// ### rtl/sler_pkg.sv
package sler_pkg;

  // Log addresses served by the block
  localparam logic [7:0] LOG_DIR     = 8'h00;
  localparam logic [7:0] LOG_ERR     = 8'h01;
  localparam logic [7:0] LOG_ST      = 8'h06;
  localparam logic [7:0] LOG_SEL     = 8'h09;
  localparam logic [7:0] LOG_HOST_LO = 8'h80;
  localparam logic [7:0] LOG_HOST_HI = 8'h9F;

  // Log directory contents
  localparam logic [7:0] LOG_VERSION  = 8'h01;
  localparam logic [7:0] ONE_SECTOR   = 8'h01;
  localparam logic [7:0] HOST_SECTORS = 8'h10;

  // Sector geometry
  localparam int SECTOR_BYTES = 512;
  localparam int CHK_OFS      = 'h1FF;

  // Error log sector layout
  localparam logic [7:0] ERR_VERSION = 8'h01;
  localparam int         ERR_PTR_OFS = 'h01;
  localparam int         ERR_FIRST   = 'h02;
  localparam int         ERR_ENTRY   = 90;
  localparam logic [2:0] ERR_SLOTS   = 3'h5;
  localparam int         ERR_CNT_OFS = 'h1C4;
  localparam logic [15:0] ERR_CNT_MAX = 16'hFFFF;

  // Error entry layout
  localparam int CMD_SNAPS     = 5;
  localparam int CMD_SNAP      = 12;
  localparam int CMD_REGS      = 8;
  localparam int CMD_MS_OFS    = 'h08;
  localparam int ERR_SNAP_OFS  = 'h3C;
  localparam int ERR_REGS_OFS  = 'h01;
  localparam int ERR_REGS      = 7;
  localparam int ERR_VEND_OFS  = 'h08;
  localparam int ERR_VEND      = 19;
  localparam int STATE_OFS     = 'h1B;
  localparam int HOURS_OFS     = 'h1C;

  // Self-test log layout
  localparam logic [7:0] ST_REV      = 8'h01;
  localparam int         ST_FIRST    = 'h02;
  localparam int         ST_DESC     = 'h18;
  localparam logic [4:0] ST_SLOTS    = 5'h15;
  localparam int         ST_NUM_REL  = 'h00;
  localparam int         ST_STAT_REL = 'h01;
  localparam int         ST_HRS_REL  = 'h02;
  localparam int         ST_CKPT_REL = 'h04;
  localparam int         ST_LBA_REL  = 'h07;
  localparam int         ST_PTR_OFS  = 'h1FC;

  // Selective self-test log read-only window
  localparam int SEL_CUR_LBA  = 'h1EC;
  localparam int SEL_CUR_SPAN = 'h1F4;
  localparam int SEL_RO_END   = 'h1F6;

  // Command key and subcommands
  localparam logic [7:0] KEY_MID     = 8'h4F;
  localparam logic [7:0] KEY_HIGH    = 8'hC2;
  localparam logic [7:0] SUB_RD_VAL  = 8'hD0;
  localparam logic [7:0] SUB_RD_THR  = 8'hD1;
  localparam logic [7:0] SUB_AUTOSV  = 8'hD2;
  localparam logic [7:0] SUB_SAVE    = 8'hD3;
  localparam logic [7:0] SUB_OFFLN   = 8'hD4;
  localparam logic [7:0] SUB_RD_LOG  = 8'hD5;
  localparam logic [7:0] SUB_WR_LOG  = 8'hD6;
  localparam logic [7:0] SUB_ENABLE  = 8'hD8;
  localparam logic [7:0] SUB_DISABLE = 8'hD9;
  localparam logic [7:0] SUB_STATUS  = 8'hDA;

  // Status and error answers
  localparam logic [7:0] STS_OK    = 8'h50;
  localparam logic [7:0] STS_FAIL  = 8'h51;
  localparam logic [7:0] ERR_NONE  = 8'h00;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] ERR_IDNF  = 8'h10;
  localparam logic [7:0] ERR_UNC   = 8'h40;
  localparam logic [7:0] ERR_AMNF  = 8'h01;

  // Register port offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_RESP = 8'h08;

  // Device state codes for the error snapshot
  typedef enum logic [3:0] {
    SLER_ST_UNKNOWN = 4'h0,
    SLER_ST_SLEEP   = 4'h1,
    SLER_ST_STANDBY = 4'h2,
    SLER_ST_ACTIVE  = 4'h3,
    SLER_ST_OFFLINE = 4'h4
  } sler_dev_state_type;

endpackage
